// >>> logic/imcol_pkg.sv
// Package for the I2C multi-master collision block: register map, fields, timing
package imcol_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] ADDR_CTRL   = 8'h00;    // Enable, request bits
    localparam logic [7:0] ADDR_STATUS = 8'h04;    // Sticky events, read clears
    localparam logic [7:0] ADDR_MASK   = 8'h08;    // Interrupt mask
    localparam logic [7:0] ADDR_TXBUF  = 8'h0C;    // Transmit shift buffer
    localparam logic [7:0] ADDR_STATE  = 8'h10;    // Live bus and engine state

    // Control register fields
    localparam int CTRL_EN    = 0;                 // Serial module enable
    localparam int CTRL_START = 1;                 // Start request
    localparam int CTRL_RSTRT = 2;                 // Repeated start request
    localparam int CTRL_STOP  = 3;                 // Stop request
    localparam int CTRL_ACK   = 4;                 // Acknowledge request
    localparam int CTRL_ACKDT = 5;                 // Acknowledge data value
    localparam int CTRL_W     = 6;

    // Status fields (same layout in mask)
    localparam int ST_BCOL  = 0;                   // Bus collision flag
    localparam int ST_SPIRQ = 1;                   // Serial port event flag
    localparam int ST_START = 2;                   // Start seen on bus
    localparam int ST_STOP  = 3;                   // Stop seen on bus
    localparam int ST_W     = 4;

    // State register fields
    localparam int SR_BF    = 0;                   // Buffer full flag
    localparam int SR_SDET  = 1;                   // Start detected, level
    localparam int SR_PDET  = 2;                   // Stop detected, level
    localparam int SR_BUSY  = 3;                   // Engine not idle

    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Quarter of an SCL bit in clock cycles (5000 ns / 8 ns = 625; four quarters ~ 50 kHz)
    localparam int HALF_NS      = 5000;
    localparam int CLK_NS       = 8;
    localparam int HALF_CYCLES  = HALF_NS / CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_STRT, ST_RPT, ST_BIT, ST_STP, ST_ACKS
    } imcol_state_type;

endpackage : imcol_pkg

// >>> logic/imcol_top.sv
// I2C master with multi-master collision detection and recovery, APB register slave
//
// Contract
// - While sending address or data, a released SDA bit sampled low flags a bus collision.
// - SDA is compared for arbitration only while SCL is released and high.
// - A collision sets the collision flag and returns the port logic to idle.
// - A collision during a byte stops shifting, clears buffer-full, releases both lines and reopens the buffer.
// - A collision during start, repeated start or acknowledge aborts it, releases the lines, clears its request bit; a stop is not compared.
// - After a collision the bus stays monitored and a detected stop sets the serial port event flag.
// - A buffer write after a collision always sends from the first data bit.
// - Start and stop conditions on the bus raise interrupts so software sees when the bus is free.
// - Start-detected and stop-detected clear on reset and while the module is disabled.
// - Reset disables the module and ends any transfer in progress.
// - Arbitration is checked during address, data, start, repeated start and acknowledge.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module imcol_top
#(
    parameter int HALF = imcol_pkg::HALF_CYCLES     // Cycles per quarter of an SCL bit
)
(
    input  wire logic        clk,                  // 125 MHz system clock
    input  wire logic        srst,                 // Synchronous reset, active high
    input  wire logic        ce,                   // Clock enable, freezes state when low
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB enable
    input  wire logic        pwrite,               // APB write
    input  wire logic [7:0]  paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error, unmapped address
    input  wire logic        scl_i,                // SCL pin level
    output logic             scl_o,                // SCL drive value, always 0
    output logic             scl_oe_n,             // SCL enable, low pulls line low
    input  wire logic        sda_i,                // SDA pin level
    output logic             sda_o,                // SDA drive value, always 0
    output logic             sda_oe_n,             // SDA enable, low pulls line low
    output logic             irq                   // Level interrupt
);
    import imcol_pkg::*;

    // How a bit is timed
    // Every bit of the link is four quarters of HALF cycles each. The engine
    // counts a quarter in cnt and steps ph at the end of it. SCL is let go at
    // the end of quarter 0 and pulled low again at the end of quarter 3, so
    // the clock line is low for one quarter and high for three.
    // SDA is changed only in the first cycle of quarter 0, one clock after SCL
    // was pulled low. Moving it together with SCL would let a receiver see the
    // new bit on the old clock level; one cycle of hold avoids that.
    //
    // Clock stretching
    // A peer may keep SCL low after we let go. In quarter 1 the timer is held
    // at zero until the synced clock is seen high, so the high time is
    // measured from the real rise, not from our release.
    //
    // Arbitration
    // Only a bit we leave released can be lost. The compare runs in quarters 1
    // to 3, when SCL is up, and only on the synced pins, so a pin edge is
    // seen about two clocks late. The acknowledge slot of a sent byte is the
    // receiver's to drive and is never compared. A stop is not arbitrated.
    //
    // Recovery
    // On a loss the engine drops whatever it was doing in the same cycle:
    // request bits are cleared, buffer-full falls, both lines are released
    // and the bit counter goes back to the first data bit. The bus monitor
    // keeps running, so the stop that the winner sends later still raises
    // the serial event flag.
    //
    // Status and interrupt
    // Status bits are sticky. A read of the status register clears the bits
    // that it returned; an event that lands in the same cycle as the read
    // stays set, so no event is lost to a read race.
    // The interrupt is a plain level of status AND mask.
    //
    // Reset and enable
    // srst clears everything and leaves both lines released, so the block
    // comes out of reset disabled and silent. While the enable bit is low the
    // start and stop detected bits are held clear and no request launches.
    // A low clock enable freezes every register, including the synchronisers.
    //
    // Bus free
    // Stop detected set, or both detected bits clear, means nobody owns the
    // bus. Software should only ask for a start in that case; the block does
    // not refuse a start on a busy bus.
    //
    // Register answers
    // Every access takes one wait state: the access edge is taken, pready and
    // read data follow one cycle later and stand for one cycle only.
    // An unmapped address answers with pslverr and zero data; writes to it
    // are ignored.
    //
    // Limitations
    // A write to the transmit buffer while the engine is busy is dropped
    // without an error; software should wait for the busy bit to fall.
    // Requests are served one at a time in a fixed order: start, repeated
    // start, stop, acknowledge, then a buffered byte.

    typedef struct packed {
        logic [1:0]            scl_s;              // SCL synchroniser
        logic [1:0]            sda_s;              // SDA synchroniser
        logic                  scl_p;              // Previous synced SCL
        logic                  sda_p;              // Previous synced SDA
        logic [CTRL_W-1:0]     ctrl;
        logic [ST_W-1:0]       stat;
        logic [ST_W-1:0]       mask;
        logic                  sdet;               // Start detected level
        logic                  pdet;               // Stop detected level
        logic                  bf;                 // Buffer full
        logic [7:0]            sh;                 // Shift register
        logic [3:0]            bitn;               // Bit index, 8 = ack slot
        logic [1:0]            ph;                 // Quarter phase within a bit
        logic [15:0]           cnt;                // Phase timer
        logic                  scl_rel;            // Released SCL
        logic                  sda_rel;            // Released SDA
        imcol_state_type       st;
        logic [31:0]           rdata;
        logic                  rdy;
    } imcol_regs_type;

    imcol_regs_type q, d;

    logic scl_h, sda_h, start_ev, stop_ev, tick, acc, wr, rd, hit, bcol;

    // Synced pin levels, only the second stage is read by logic
    assign scl_h    = q.scl_s[1];
    assign sda_h    = q.sda_s[1];
    assign start_ev = scl_h && q.scl_p && q.sda_p && !sda_h;
    assign stop_ev  = scl_h && q.scl_p && !q.sda_p && sda_h;
    assign tick     = (q.cnt == 16'(HALF - 1));
    assign acc      = psel && penable && !q.rdy;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign hit      = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_MASK)
                      || (paddr == ADDR_TXBUF) || (paddr == ADDR_STATE);

    // Collision: we released SDA, SCL is really high, yet SDA reads low
    // The acknowledge slot of a sent byte belongs to the receiver, never compared
    assign bcol = (q.st != ST_IDLE) && (q.st != ST_STP) && q.sda_rel && q.scl_rel
                  && !(q.st == ST_BIT && q.bitn == 4'd8)
                  && scl_h && !sda_h && (q.ph != 2'd0);

    always_comb
    begin
        d = q;
        d.scl_s = {q.scl_s[0], scl_i};
        d.sda_s = {q.sda_s[0], sda_i};
        d.scl_p = scl_h;
        d.sda_p = sda_h;
        d.rdy   = acc;

        // Status read clears what it returned; events below set again, so set wins
        if (rd && paddr == ADDR_STATUS)
            d.stat = '0;

        // Bus condition monitor, live even while a collision recovers
        if (start_ev)
        begin
            d.sdet = 1'b1;
            d.pdet = 1'b0;
            d.stat[ST_START] = 1'b1;
        end
        if (stop_ev)
        begin
            d.pdet = 1'b1;
            d.sdet = 1'b0;
            d.stat[ST_STOP]  = 1'b1;
            d.stat[ST_SPIRQ] = 1'b1;
        end

        // Bit engine, four quarters per bit, SCL high during quarters 1 to 3
        if (q.st != ST_IDLE)
        begin
            d.cnt = tick ? 16'h0000 : q.cnt + 16'h0001;
            // Clock stretching: hold the high phase until SCL is seen high
            if (q.scl_rel && !scl_h && q.ph == 2'd1)
                d.cnt = 16'h0000;
        end
        if (q.st != ST_IDLE && tick && !(q.scl_rel && !scl_h && q.ph == 2'd1))
        begin
            d.ph = q.ph + 2'd1;
            unique case (q.st)
                ST_STRT, ST_RPT:
                begin
                    // Q0: SDA and SCL up, Q2: SDA down, Q3: SCL down
                    if (q.ph == 2'd0) d.sda_rel = 1'b1;
                    if (q.ph == 2'd0) d.scl_rel = 1'b1;
                    if (q.ph == 2'd2) d.sda_rel = 1'b0;
                    if (q.ph == 2'd3)
                    begin
                        d.scl_rel = 1'b0;
                        d.st = ST_IDLE;
                        d.ctrl[CTRL_START] = 1'b0;
                        d.ctrl[CTRL_RSTRT] = 1'b0;
                    end
                end
                ST_STP:
                begin
                    if (q.ph == 2'd0) d.sda_rel = 1'b0;
                    if (q.ph == 2'd1) d.scl_rel = 1'b1;
                    if (q.ph == 2'd2) d.sda_rel = 1'b1;
                    if (q.ph == 2'd3)
                    begin
                        d.st = ST_IDLE;
                        d.ctrl[CTRL_STOP] = 1'b0;
                    end
                end
                ST_BIT, ST_ACKS:
                begin
                    if (q.ph == 2'd0)
                    begin
                        d.scl_rel = 1'b1;
                    end
                    if (q.ph == 2'd3)
                    begin
                        d.scl_rel = 1'b0;
                        if (q.st == ST_ACKS)
                        begin
                            d.st = ST_IDLE;
                            d.ctrl[CTRL_ACK] = 1'b0;
                            d.stat[ST_SPIRQ] = 1'b1;
                        end
                        else if (q.bitn == 4'd8)
                        begin
                            d.st = ST_IDLE;
                            d.bf = 1'b0;
                            d.stat[ST_SPIRQ] = 1'b1;
                        end
                        else
                        begin
                            d.sh   = {q.sh[6:0], 1'b0};
                            d.bitn = q.bitn + 4'd1;
                        end
                    end
                end
                default: d.st = ST_IDLE;
            endcase
        end

        // New data bit goes out one cycle after SCL fell, never on a clock edge
        if ((q.st == ST_BIT || q.st == ST_ACKS) && q.ph == 2'd0 && q.cnt == 16'h0000)
        begin
            d.sda_rel = (q.st == ST_ACKS) ? q.ctrl[CTRL_ACKDT]
                      : (q.bitn == 4'd8) ? 1'b1 : q.sh[7];
        end

        // Launch a pending request from idle, start first
        if (q.st == ST_IDLE && q.ctrl[CTRL_EN])
        begin
            d.ph  = 2'd0;
            d.cnt = 16'h0000;
            if (q.ctrl[CTRL_START])      d.st = ST_STRT;
            else if (q.ctrl[CTRL_RSTRT]) d.st = ST_RPT;
            else if (q.ctrl[CTRL_STOP])  d.st = ST_STP;
            else if (q.ctrl[CTRL_ACK])   d.st = ST_ACKS;
            else if (q.bf)
            begin
                d.st   = ST_BIT;
                d.bitn = 4'd0;
            end
        end

        // APB register writes
        if (wr && paddr == ADDR_CTRL)
            d.ctrl = pwdata[CTRL_W-1:0];
        if (wr && paddr == ADDR_MASK)
            d.mask = pwdata[ST_W-1:0];
        if (wr && paddr == ADDR_TXBUF && q.st == ST_IDLE)
        begin
            d.sh = pwdata[7:0];
            d.bf = 1'b1;
        end

        // Collision recovery, dominates the engine
        if (bcol)
        begin
            d.stat[ST_BCOL] = 1'b1;
            d.st      = ST_IDLE;
            d.bf      = 1'b0;
            d.bitn    = 4'd0;
            d.scl_rel = 1'b1;
            d.sda_rel = 1'b1;
            d.ctrl[CTRL_START] = 1'b0;
            d.ctrl[CTRL_RSTRT] = 1'b0;
            d.ctrl[CTRL_STOP]  = 1'b0;
            d.ctrl[CTRL_ACK]   = 1'b0;
        end

        // Read answer; a status read clears bits not set this cycle
        d.rdata = 32'h0000_0000;
        if (rd)
        begin
            unique case (paddr)
                ADDR_CTRL:   d.rdata = 32'(q.ctrl);
                ADDR_STATUS: d.rdata = 32'(q.stat);
                ADDR_MASK:   d.rdata = 32'(q.mask);
                ADDR_TXBUF:  d.rdata = 32'(q.sh);
                ADDR_STATE:  d.rdata = {28'h000_0000, q.st != ST_IDLE, q.pdet, q.sdet, q.bf};
                default:     d.rdata = 32'h0000_0000;
            endcase
        end
        // Disabled module: detectors cleared, engine idle, lines released
        if (!q.ctrl[CTRL_EN])
        begin
            d.sdet    = 1'b0;
            d.pdet    = 1'b0;
            d.st      = ST_IDLE;
            d.scl_rel = 1'b1;
            d.sda_rel = 1'b1;
        end
    end

    // Single state register; reset disables and ends transfers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q         <= '0;
            q.scl_s   <= 2'b11;
            q.sda_s   <= 2'b11;
            q.scl_p   <= 1'b1;
            q.sda_p   <= 1'b1;
            q.scl_rel <= 1'b1;
            q.sda_rel <= 1'b1;
            q.st      <= ST_IDLE;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // Outputs; open drain pins drive low only
    assign prdata   = q.rdata;
    assign pready   = q.rdy;
    assign pslverr  = q.rdy && !hit;
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = q.scl_rel;
    assign sda_oe_n = q.sda_rel;
    assign irq      = |(q.stat & q.mask);

endmodule : imcol_top

`default_nettype wire

// >>> sim/imcol_peer.sv
// Competing bus master that steals the data line on one chosen bit
`timescale 1ns/1ns
`default_nettype none
module imcol_peer
(
    input  wire logic       scl,            // Clock wire
    input  wire logic       sda,            // Data wire
    input  wire logic       arm,            // Rise restarts counts
    input  wire logic [3:0] grab_at,        // Clock fall to pull on, 0 never
    output logic            pull_n,         // Low pulls data low
    output logic [7:0]      rx_byte,        // First eight bits seen
    output logic            done            // Steal and stop finished
);
    int falls;
    int rises;

    initial pull_n = 1'b1;
    // Counts restart on arming so each scenario is counted afresh
    always @(posedge arm)
    begin
        falls = 0;
        rises = 0;
        done = 1'b0;
        rx_byte = 8'h00;
    end
    // Bits are taken at the clock rise, where data must already be stable
    always @(posedge scl)
    begin
        rises = rises + 1;
        if (arm && rises <= 8)
            rx_byte = {rx_byte[6:0], sda};
    end
    // Pull only with the clock low; letting go with the clock high makes a stop
    always @(negedge scl)
    begin
        falls = falls + 1;
        if (arm && falls == int'(grab_at))
        begin
            pull_n = 1'b0;
            @(posedge scl);
            #640;
            pull_n = 1'b1;
            done = 1'b1;
        end
    end
endmodule : imcol_peer
`default_nettype wire

// >>> sim/imcol_properties.sv
// Port checker for the collision block
`timescale 1ns/1ns
`default_nettype none
module imcol_properties
#(
    parameter int HALF = 8                  // Cycles per quarter of a clock bit
)
(
    input wire logic        clk,            // System clock
    input wire logic        srst,           // Sync reset
    input wire logic        ce,             // Clock enable
    input wire logic        psel,           // APB select
    input wire logic        penable,        // APB enable
    input wire logic [31:0] prdata,         // Read data
    input wire logic        pready,         // Ready
    input wire logic        pslverr,        // Error
    input wire logic        scl_i,          // Clock wire
    input wire logic        scl_o,          // Clock drive value
    input wire logic        scl_oe_n,       // Clock pull
    input wire logic        sda_i,          // Data wire
    input wire logic        sda_o,          // Data drive value
    input wire logic        sda_oe_n,       // Data pull
    input wire logic        irq             // Interrupt
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);
    int low_q;

    // Count low cycles so a too short low quarter shows at release
    always_ff @(posedge clk)
        low_q <= (srst || scl_oe_n) ? 0 : low_q + 1;
    // Foreign low on a bit we leave released, with the clock up
    sequence s_lost;
        (sda_oe_n && scl_oe_n && scl_i && !sda_i) [*4];
    endsequence
    sequence s_idle;
        (sda_oe_n && scl_oe_n) [*8];
    endsequence

    AST_APB_WAIT: assert property (psel && penable && !pready && ce |=> pready)
        else $error("no ready after access");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held");
    AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("bad error answer");
    AST_RESET_IDLE: assert property ($fell(srst) |-> sda_oe_n && scl_oe_n && !pready && !irq)
        else $error("not idle after reset");
    AST_PULL_ONLY: assert property (!sda_o && !scl_o)
        else $error("line driven high");
    AST_LOST_RELEASE: assert property (s_lost |=> s_idle)
        else $error("lines held after lost bit");
    AST_START_SHAPE: assert property ($fell(sda_oe_n) && scl_i && scl_oe_n |-> ##[1:20] !scl_oe_n)
        else $error("start not followed by clock low");
    AST_SCL_LOW_HOLD: assert property ($rose(scl_oe_n) |-> low_q >= HALF)
        else $error("clock low too short");
endmodule : imcol_properties

bind imcol_top imcol_properties #(.HALF(HALF)) imcol_properties_i (.clk(clk), .srst(srst), .ce(ce),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire

// >>> sim/imcol_top_tb_top.sv
// Self-checking bench for the collision block against a competing master
`timescale 1ns/1ns
`default_nettype none
module imcol_top_tb_top;
    import imcol_pkg::*;
    logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr, scl_o, scl_oe_n;
    logic        sda_o, sda_oe_n, irq, pull_n, arm, done;
    logic [7:0]  paddr, rx_byte, byte_a;
    logic [31:0] pwdata, prdata, rnd;
    logic [3:0]  grab_at;
    logic [64:0] note;
    logic [64:0] notes[$];                  // Queued {error, mask, value} per transfer
    int          num_errors, tests_run, n;
    // Pulled-up open-drain wires; only the block drives the clock
    wire logic   scl_w = scl_oe_n;
    wire logic   sda_w = sda_oe_n & pull_n;

    imcol_top #(.HALF(5)) imcol_top_i (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .irq(irq));
    imcol_peer imcol_peer_i (.scl(scl_w), .sda(sda_w), .arm(arm), .grab_at(grab_at), .pull_n(pull_n),
        .rx_byte(rx_byte), .done(done));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // One APB transfer; request held until ready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [31:0] v, input logic err);
        notes.push_back({err, m, v});
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for the interrupt level, then compared
    task automatic wait_irq(input logic lvl);
        for (n = 0; n < 5000 && irq !== lvl; n++) @(posedge clk);
        check({31'h0, irq}, {31'h0, lvl});
    endtask : wait_irq

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Scoreboard: each answer against the oldest expectation
    always @(posedge clk)
    begin
        if (pready === 1'b1)
        begin
            note = notes.pop_front();
            check({31'h0, pslverr}, {31'h0, note[64]});
            check(prdata & note[63:32], note[31:0]);
        end
    end
    // Watchdog cuts a hang short
    initial
    begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite, arm} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        grab_at = 4'h0;
        num_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, ADDR_CTRL, 0, '1, 0, 1'b0);
        apb(1'b0, ADDR_STATUS, 0, '1, 0, 1'b0);
        apb(1'b0, ADDR_STATE, 0, '1, 0, 1'b0);
        apb(1'b0, 8'h14, 0, '1, 0, 1'b1);
        apb(1'b1, 8'h14, 32'hffff_ffff, 0, 0, 1'b1);
        apb(1'b1, ADDR_MASK, 32'h0000_000f, 0, 0, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001, 0, 0, 1'b0);
        // Peer pulls low on a random bit that we send as one
        rnd = xorshift(32'he454_b1db);
        byte_a = rnd[15:8] | (8'h80 >> rnd[2:0]);
        grab_at <= {1'b0, rnd[2:0]} + 4'h1;
        arm <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003, 0, 0, 1'b0);
        wait_irq(1'b1);
        apb(1'b0, ADDR_STATUS, 0, 32'h0000_0005, 32'h0000_0004, 1'b0);
        apb(1'b1, ADDR_TXBUF, {24'h0, byte_a}, 0, 0, 1'b0);
        for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge clk);
        apb(1'b1, ADDR_MASK, 0, 0, 0, 1'b0);
        wait_irq(1'b0);
        apb(1'b1, ADDR_MASK, 32'h0000_000f, 0, 0, 1'b0);
        wait_irq(1'b1);
        apb(1'b0, ADDR_STATUS, 0, 32'h0000_000b, 32'h0000_000b, 1'b0);
        apb(1'b0, ADDR_STATUS, 0, 32'h0000_000f, 0, 1'b0);
        apb(1'b0, ADDR_STATE, 0, 32'h0000_000f, 32'h0000_0004, 1'b0);
        apb(1'b0, ADDR_CTRL, 0, '1, 32'h0000_0001, 1'b0);
        // New start only once the stop is seen; the next byte goes out whole
        arm <= 1'b0;
        grab_at <= 4'h0;
        byte_a = rnd[23:16];
        @(posedge clk);
        arm <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003, 0, 0, 1'b0);
        wait_irq(1'b1);
        apb(1'b0, ADDR_STATUS, 0, 32'h0000_0005, 32'h0000_0004, 1'b0);
        apb(1'b1, ADDR_TXBUF, {24'h0, byte_a}, 0, 0, 1'b0);
        apb(1'b0, ADDR_STATE, 0, 32'h0000_0001, 32'h0000_0001, 1'b0);
        wait_irq(1'b1);
        check({24'h0, rx_byte}, {24'h0, byte_a});
        apb(1'b0, ADDR_STATUS, 0, 32'h0000_0003, 32'h0000_0002, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0009, 0, 0, 1'b0);
        wait_irq(1'b1);
        apb(1'b0, ADDR_STATUS, 0, 32'h0000_000f, 32'h0000_000a, 1'b0);
        apb(1'b0, ADDR_CTRL, 0, '1, 32'h0000_0001, 1'b0);
        tally_and_finish();
    end
endmodule : imcol_top_tb_top
`default_nettype wire
